// [design/sinc_decimation_spi_readout.sv]
`timescale 1ns/1ps
module sinc_decimation_spi_readout (
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic i_sclk,
  input wire logic i_cs_n,
  input wire logic i_mosi,
  output logic o_miso,
  output logic o_miso_oe,
  input wire logic i_chan_one_modulator_clock,
  input wire logic i_chan_two_modulator_clock,
  input wire logic i_chan_three_modulator_clock,
  input wire logic i_modulator_bitstream_one,
  input wire logic i_modulator_bitstream_two,
  input wire logic i_modulator_bitstream_three,
  output logic o_result_ready_flag,
  output logic o_int_n
);

  // ****************************************
  // Serial pin synchronisers
  // ****************************************
  logic sclk_meta, sclk_sync, sclk_prev, cs_meta, cs_sync, cs_prev, mosi_meta, mosi_sync;
  logic sclk_rise, sclk_fall, cs_fall, cs_low;

  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      sclk_meta <= 1'b0;
      sclk_sync <= 1'b0;
      sclk_prev <= 1'b0;
      cs_meta <= 1'b1;
      cs_sync <= 1'b1;
      cs_prev <= 1'b1;
      mosi_meta <= 1'b0;
      mosi_sync <= 1'b0;
    end else begin
      sclk_meta <= i_sclk;
      sclk_sync <= sclk_meta;
      sclk_prev <= sclk_sync;
      cs_meta <= i_cs_n;
      cs_sync <= cs_meta;
      cs_prev <= cs_sync;
      mosi_meta <= i_mosi;
      mosi_sync <= mosi_meta;
    end
  end

  assign sclk_rise = sclk_sync & ~sclk_prev;
  assign sclk_fall = ~sclk_sync & sclk_prev;
  assign cs_fall = ~cs_sync & cs_prev;
  assign cs_low = ~cs_sync;

  // ****************************************
  // Channels
  // ****************************************
  logic [2:0] mod_clocks, mod_data, mod_edge, chan_done, sel_mask, done_flags;
  logic [15:0] chan_result [3];
  logic [15:0] offset [3];
  logic [15:0] out_result [3];
  logic [7:0] config_zero;
  logic [1:0] chan_select;
  logic conv_start, ready, running;
  logic [1:0] res_idx;
  sinc_readout_pkg::check_state_e check_state;

  assign mod_clocks = {i_chan_three_modulator_clock, i_chan_two_modulator_clock,
                       i_chan_one_modulator_clock};
  assign mod_data = {i_modulator_bitstream_three, i_modulator_bitstream_two,
                     i_modulator_bitstream_one};
  assign running = (check_state == sinc_readout_pkg::RUNNING);

  always_comb begin
    unique case (chan_select)
      sinc_readout_pkg::SEL_ONE: sel_mask = 3'h1;
      sinc_readout_pkg::SEL_TWO: sel_mask = 3'h3;
      default: sel_mask = 3'h7;
    endcase
  end

  for (genvar ch = 0; ch < 3; ch++) begin : g_chan
    sinc_channel u_chan (
      .i_clock(i_clock),
      .i_sys_rst(i_sys_rst),
      .i_mod_clock(mod_clocks[ch]),
      .i_mod_data(mod_data[ch]),
      .i_start(conv_start & sel_mask[ch]),
      .i_mode(config_zero[sinc_readout_pkg::MODE_LSB +: sinc_readout_pkg::MODE_W]),
      .o_mod_edge(mod_edge[ch]),
      .o_done(chan_done[ch]),
      .o_result(chan_result[ch])
    );
    // Corrected only when offset enable is set
    assign out_result[ch] = config_zero[sinc_readout_pkg::OFFSET_EN_BIT] ?
        sinc_readout_pkg::offset_correct(chan_result[ch], offset[ch]) :
        chan_result[ch];
  end

  // ****************************************
  // Power-up clock check
  // ****************************************
  logic [15:0] check_cnt;
  logic [3:0] edge_cnt;

  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      check_state <= sinc_readout_pkg::CHECKING;
      check_cnt <= 16'h0000;
      edge_cnt <= 4'h0;
      o_int_n <= 1'b1;
    end else begin
      unique case (check_state)
        sinc_readout_pkg::CHECKING: begin
          check_cnt <= check_cnt + 16'h0001;
          if (mod_edge[0]) edge_cnt <= edge_cnt + 4'h1;
          if (edge_cnt >= sinc_readout_pkg::CLK_CHECK_EDGES) begin
            check_state <= sinc_readout_pkg::RUNNING;
          end else if (check_cnt == 16'(sinc_readout_pkg::CLK_CHECK_CYCLES - 1)) begin
            check_state <= sinc_readout_pkg::FAULTED;
          end
        end
        sinc_readout_pkg::RUNNING: check_state <= sinc_readout_pkg::RUNNING;
        sinc_readout_pkg::FAULTED: check_state <= sinc_readout_pkg::FAULTED;
      endcase
      o_int_n <= (check_state != sinc_readout_pkg::FAULTED);
    end
  end

  // ****************************************
  // Conversion control and ready
  // ****************************************
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      conv_start <= 1'b0;
      done_flags <= 3'h0;
      ready <= 1'b0;
      o_result_ready_flag <= 1'b0;
    end else begin
      conv_start <= cs_fall & running;
      // Done pulses of an abandoned conversion must not raise ready
      if ((cs_fall && running) || conv_start) begin
        done_flags <= 3'h0;
        ready <= 1'b0;
      end else begin
        done_flags <= done_flags | chan_done;
        // Slowest selected channel decides
        if ((done_flags & sel_mask) == sel_mask && !conv_start) ready <= 1'b1;
      end
      o_result_ready_flag <= ready;
    end
  end

  // Offsets are loaded only by a calibrated conversion
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      offset <= '{default: sinc_readout_pkg::OFFSET_RESET};
    end else begin
      for (int ch = 0; ch < 3; ch++) begin
        if (chan_done[ch] && config_zero[sinc_readout_pkg::CAL_BIT]) begin
          offset[ch] <= chan_result[ch];
        end
      end
    end
  end

  // ****************************************
  // Serial port
  // ****************************************
  logic [3:0] bit_cnt, rd_addr;
  logic [15:0] rx, tx, next_tx, word_in, load_word;
  logic [7:0] rd_data;
  logic [1:0] nchan;

  assign word_in = {rx[14:0], mosi_sync};
  assign rd_addr = rx[3:0];
  assign nchan = (sel_mask == 3'h1) ? 2'h1 : (sel_mask == 3'h3) ? 2'h2 : 2'h3;

  always_comb begin
    unique case (rd_addr)
      sinc_readout_pkg::REG_CONFIG_ZERO: rd_data = config_zero;
      sinc_readout_pkg::REG_CHAN_SELECT: rd_data = {6'h00, chan_select};
      sinc_readout_pkg::REG_STATUS: rd_data = {7'h00, ready};
      4'h4: rd_data = offset[0][15:8];
      4'h5: rd_data = offset[0][7:0];
      4'h6: rd_data = offset[1][15:8];
      4'h7: rd_data = offset[1][7:0];
      4'h8: rd_data = offset[2][15:8];
      4'h9: rd_data = offset[2][7:0];
      default: rd_data = 8'h00;
    endcase
    load_word = (ready && res_idx < nchan) ? out_result[res_idx] : 16'h0000;
    if (cs_fall || bit_cnt == 4'h0) next_tx = load_word;
    else if (bit_cnt == sinc_readout_pkg::READ_LOAD_BIT && rx[7] && !rx[6]) begin
      next_tx = {rd_data, 8'h00};
    end else next_tx = {tx[14:0], 1'b0};
  end

  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      bit_cnt <= 4'h0;
      rx <= 16'h0000;
      res_idx <= 2'h0;
      config_zero <= sinc_readout_pkg::CONFIG_ZERO_RESET;
      chan_select <= sinc_readout_pkg::CHAN_SELECT_RESET;
    end else if (cs_fall) begin
      bit_cnt <= 4'h0;
      res_idx <= 2'h0;
    end else if (cs_low && running && sclk_rise) begin
      rx <= word_in;
      bit_cnt <= bit_cnt + 4'h1;
      if (bit_cnt == sinc_readout_pkg::LAST_BIT) begin
        if (word_in[sinc_readout_pkg::CMD_BIT] && word_in[sinc_readout_pkg::WRITE_BIT]) begin
          unique case (word_in[sinc_readout_pkg::ADDR_LSB +: 4])
            sinc_readout_pkg::REG_CONFIG_ZERO: config_zero <= word_in[7:0];
            sinc_readout_pkg::REG_CHAN_SELECT: begin
              chan_select <= word_in[sinc_readout_pkg::CHAN_SEL_W-1:0];
            end
            default: ;
          endcase
        end else if (!word_in[sinc_readout_pkg::CMD_BIT] && ready && res_idx < nchan) begin
          res_idx <= res_idx + 2'h1;
        end
      end
    end
  end

  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      tx <= 16'h0000;
      o_miso <= 1'b0;
      o_miso_oe <= 1'b0;
    end else begin
      o_miso_oe <= cs_low & running;
      if ((cs_fall && running) || (cs_low && running && sclk_fall)) begin
        tx <= next_tx;
        o_miso <= next_tx[15];
      end
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);

  property p_start;
    cs_fall && running |=> conv_start ##1 !conv_start;
  endproperty
  a_start: assert property (p_start) else $error("conversion not started");

  property p_ready_clear;
    cs_fall && running |=> !ready [*2];
  endproperty
  a_ready_clear: assert property (p_ready_clear) else $error("ready not cleared");

  property p_ready_rise;
    $rose(ready) |-> $past((done_flags & sel_mask) == sel_mask);
  endproperty
  a_ready_rise: assert property (p_ready_rise) else $error("ready before slowest");

  property p_word_wrap;
    cs_low && running && sclk_rise && bit_cnt == 4'hF && !cs_fall |=> bit_cnt == 4'h0;
  endproperty
  a_word_wrap: assert property (p_word_wrap) else $error("word not 16 bits");

  property p_idx_step;
    res_idx != $past(res_idx) |-> res_idx == $past(res_idx) + 2'h1 || res_idx == 2'h0;
  endproperty
  a_idx_step: assert property (p_idx_step) else $error("channel order broken");

  property p_miso_fall;
    $changed(o_miso) |-> $past(cs_fall || sclk_fall);
  endproperty
  a_miso_fall: assert property (p_miso_fall) else $error("miso moved off edge");

  property p_write_cs;
    $changed(config_zero) |-> $past(cs_low && sclk_rise && bit_cnt == 4'hF);
  endproperty
  a_write_cs: assert property (p_write_cs) else $error("write outside frame");

  property p_cal_capture;
    chan_done[0] && config_zero[sinc_readout_pkg::CAL_BIT] |=> offset[0] == $past(chan_result[0]);
  endproperty
  a_cal_capture: assert property (p_cal_capture) else $error("offset not captured");

  property p_fault_int;
    check_state == sinc_readout_pkg::FAULTED |=> !o_int_n && !conv_start;
  endproperty
  a_fault_int: assert property (p_fault_int) else $error("fault not flagged");

endmodule : sinc_decimation_spi_readout

// [design/sinc_readout_pkg.sv]
package sinc_readout_pkg;

  // ****************************************
  // Widths and word layout
  // ****************************************
  localparam int RESULT_W = 16;
  localparam int ACC_W = 25;
  localparam int WORD_BITS = 16;
  localparam int CMD_BIT = 15;
  localparam int WRITE_BIT = 14;
  localparam int ADDR_LSB = 8;
  localparam logic [3:0] LAST_BIT = 4'hF;
  localparam logic [3:0] READ_LOAD_BIT = 4'h8;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [3:0] REG_CONFIG_ZERO = 4'h0;
  localparam logic [3:0] REG_CHAN_SELECT = 4'h1;
  localparam logic [3:0] REG_STATUS = 4'h2;
  localparam logic [3:0] REG_OFFSET_BASE = 4'h4;
  localparam logic [3:0] REG_OFFSET_LAST = 4'h9;
  localparam int CAL_BIT = 6;
  localparam int OFFSET_EN_BIT = 5;
  localparam int MODE_LSB = 0;
  localparam int MODE_W = 3;
  localparam int CHAN_SEL_W = 2;
  localparam logic [7:0] CONFIG_ZERO_RESET = 8'h00;
  localparam logic [1:0] CHAN_SELECT_RESET = 2'h0;
  localparam logic [1:0] SEL_ONE = 2'h0;
  localparam logic [1:0] SEL_TWO = 2'h1;
  localparam logic [15:0] OFFSET_RESET = 16'h8000;
  localparam logic [15:0] MIDSCALE = 16'h8000;

  // ****************************************
  // Filter modes
  // ****************************************
  localparam logic [2:0] MODE_SINC3_FIRST = 3'h4;
  localparam logic [1:0] LAST_DEC_SINC2 = 2'h1;
  localparam logic [1:0] LAST_DEC_SINC3 = 2'h2;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_FREQ_MHZ = 100;
  localparam int CLK_CHECK_TIME_NS = 10000;
  localparam int CLK_CHECK_CYCLES = CLK_FREQ_MHZ * CLK_CHECK_TIME_NS / 1000;
  localparam logic [3:0] CLK_CHECK_EDGES = 4'h4;

  typedef enum logic [1:0] {CHECKING, RUNNING, FAULTED} check_state_e;

  function automatic logic [3:0] mode_log2_ratio(input logic [2:0] mode);
    case (mode)
      3'h0: mode_log2_ratio = 4'h7;
      3'h1: mode_log2_ratio = 4'h8;
      3'h2: mode_log2_ratio = 4'h9;
      3'h3: mode_log2_ratio = 4'hA;
      3'h4: mode_log2_ratio = 4'h6;
      3'h5: mode_log2_ratio = 4'h7;
      3'h6: mode_log2_ratio = 4'h8;
      default: mode_log2_ratio = 4'h7;
    endcase
  endfunction : mode_log2_ratio

  function automatic logic mode_is_third(input logic [2:0] mode);
    mode_is_third = (mode >= MODE_SINC3_FIRST) && (mode != 3'h7);
  endfunction : mode_is_third

  // Offset-binary correction, clipped to the 16-bit range
  function automatic logic [15:0] offset_correct(input logic [15:0] raw, input logic [15:0] off);
    logic signed [18:0] diff;
    diff = $signed({3'h0, raw}) - $signed({3'h0, off}) + $signed({3'h0, MIDSCALE});
    if (diff < 0) offset_correct = 16'h0000;
    else if (diff > $signed(19'h0FFFF)) offset_correct = 16'hFFFF;
    else offset_correct = diff[15:0];
  endfunction : offset_correct

endpackage : sinc_readout_pkg

// [design/sinc_channel.sv]
`timescale 1ns/1ps
module sinc_channel #(
  parameter int ACC_W = sinc_readout_pkg::ACC_W
) (
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic i_mod_clock,
  input wire logic i_mod_data,
  input wire logic i_start,
  input wire logic [2:0] i_mode,
  output logic o_mod_edge,
  output logic o_done,
  output logic [15:0] o_result
);

  // ****************************************
  // Modulator pin synchronisers
  // ****************************************
  logic clk_meta, clk_sync, clk_prev, dat_meta, dat_sync;
  logic edge_now;

  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      clk_meta <= 1'b0;
      clk_sync <= 1'b0;
      clk_prev <= 1'b0;
      dat_meta <= 1'b0;
      dat_sync <= 1'b0;
    end else begin
      clk_meta <= i_mod_clock;
      clk_sync <= clk_meta;
      clk_prev <= clk_sync;
      dat_meta <= i_mod_data;
      dat_sync <= dat_meta;
    end
  end

  assign edge_now = clk_sync & ~clk_prev;

  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) o_mod_edge <= 1'b0;
    else o_mod_edge <= edge_now;
  end

  // ****************************************
  // Integrators and combs
  // ****************************************
  logic busy, third;
  logic [3:0] lgd;
  logic [9:0] dec_cnt, ratio_m1;
  logic [1:0] dec_num;
  logic [ACC_W-1:0] int1, int2, int3, z1, z2, z3;
  logic [ACC_W-1:0] next_int1, next_int2, next_int3, top, c1, c2, c3, filt;
  logic [4:0] lgdk;
  logic [ACC_W+15:0] scaled;
  logic [15:0] next_result;

  always_comb begin
    next_int1 = int1 + ACC_W'(dat_sync);
    next_int2 = int2 + next_int1;
    next_int3 = int3 + next_int2;
    top = third ? next_int3 : next_int2;
    c1 = top - z1;
    c2 = c1 - z2;
    c3 = c2 - z3;
    filt = third ? c3 : c2;
    ratio_m1 = 10'((11'h001 << lgd) - 11'h001);
    lgdk = third ? 5'(lgd) * 5'h03 : 5'(lgd) * 5'h02;
    scaled = {filt, 16'h0000} >> lgdk;
    // Full-scale ones would read 0x10000
    next_result = (|scaled[ACC_W+15:16]) ? 16'hFFFF : scaled[15:0];
  end

  // Window is D*K modulator periods from the start pulse
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      busy <= 1'b0;
      third <= 1'b0;
      lgd <= 4'h7;
      dec_cnt <= 10'h000;
      dec_num <= 2'h0;
      int1 <= '0;
      int2 <= '0;
      int3 <= '0;
      z1 <= '0;
      z2 <= '0;
      z3 <= '0;
      o_done <= 1'b0;
      o_result <= 16'h0000;
    end else begin
      o_done <= 1'b0;
      if (i_start) begin
        busy <= 1'b1;
        third <= sinc_readout_pkg::mode_is_third(i_mode);
        lgd <= sinc_readout_pkg::mode_log2_ratio(i_mode);
        dec_cnt <= 10'h000;
        dec_num <= 2'h0;
        int1 <= '0;
        int2 <= '0;
        int3 <= '0;
        z1 <= '0;
        z2 <= '0;
        z3 <= '0;
      end else if (busy && edge_now) begin
        int1 <= next_int1;
        int2 <= next_int2;
        int3 <= next_int3;
        if (dec_cnt == ratio_m1) begin
          dec_cnt <= 10'h000;
          z1 <= top;
          z2 <= c1;
          z3 <= c2;
          dec_num <= dec_num + 2'h1;
          if (dec_num == (third ? sinc_readout_pkg::LAST_DEC_SINC3
                                : sinc_readout_pkg::LAST_DEC_SINC2)) begin
            busy <= 1'b0;
            o_done <= 1'b1;
            o_result <= next_result;
          end
        end else begin
          dec_cnt <= dec_cnt + 10'h001;
        end
      end
    end
  end

endmodule : sinc_channel

// [testbench/spi_master_model.sv]
`timescale 1ns/1ps
module spi_master_model (
  output logic o_sclk,
  output logic o_cs_n,
  output logic o_mosi,
  input wire logic i_miso
);
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_mosi = 1'b0;
  end

  // ****************************************
  // Mode zero master, 80 ns half period
  // ****************************************
  // Idle clock low, edges well apart from select
  task automatic select(input logic low);
    #80;
    o_cs_n = ~low;
    #80;
  endtask : select

  // Whole 16-bit words, MSB first; data moves on the falling edge
  task automatic word(input logic [15:0] tx, output logic [15:0] rx);
    for (int i = 15; i >= 0; i--) begin
      o_mosi = tx[i];
      #80;
      o_sclk = 1'b1;
      rx[i] = i_miso;
      #80;
      o_sclk = 1'b0;
    end
    // Stale data line shows the inverse, not the last bit
    o_mosi = ~o_mosi;
  endtask : word
endmodule : spi_master_model

// [testbench/sinc_decimation_spi_readout_tb.sv]
`timescale 1ns/1ps
module sinc_decimation_spi_readout_tb;
  logic i_clock;
  logic i_sys_rst;
  logic sclk;
  logic cs_n;
  logic mosi;
  logic miso;
  logic miso_oe;
  logic miso_line;
  logic ready;
  logic int_n;
  logic [2:0] mclk;
  logic [2:0] modulator_bitstream;
  int mph[3];
  logic mclk_run = 1'b0;
  logic [7:0] rd;
  int errors = 0;
  int tests_run = 0;
  int offs[3] = '{32'h8000, 32'h8000, 32'h8000};
  int n;

  always #5 i_clock = ~i_clock;
  // Unrelated modulator rates, third channel slowest
  function automatic int mhalf(input int k);
    return (k == 0) ? 50 : (k == 1) ? 48 : 53;
  endfunction : mhalf

  // Edges land on falling clock edges; a phase sum keeps the odd rates
  always @(negedge i_clock) begin
    for (int k = 0; k < 3; k++) begin
      if (mclk_run) begin
        mph[k] = mph[k] + 10;
        if (mph[k] >= mhalf(k)) begin
          mph[k] = mph[k] - mhalf(k);
          mclk[k] = ~mclk[k];
        end
      end
    end
  end
  // No pull on the line: a released output reads inverted
  assign miso_line = miso_oe ? miso : ~miso;

  spi_master_model spi (.o_sclk(sclk), .o_cs_n(cs_n), .o_mosi(mosi), .i_miso(miso_line));

  sinc_decimation_spi_readout dut (
    .i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_sclk(sclk), .i_cs_n(cs_n), .i_mosi(mosi),
    .o_miso(miso), .o_miso_oe(miso_oe),
    .i_chan_one_modulator_clock(mclk[0]), .i_chan_two_modulator_clock(mclk[1]),
    .i_chan_three_modulator_clock(mclk[2]), .i_modulator_bitstream_one(modulator_bitstream[0]),
    .i_modulator_bitstream_two(modulator_bitstream[1]), .i_modulator_bitstream_three(modulator_bitstream[2]),
    .o_result_ready_flag(ready), .o_int_n(int_n)
  );

  // ****************************************
  // Tasks and model
  // ****************************************
  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", name, exp, got);
      errors++;
    end
  endtask : check

  task automatic finish_test();
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : finish_test

  task automatic do_reset();
    @(negedge i_clock);
    i_sys_rst = 1'b1;
    repeat (4) @(negedge i_clock);
    i_sys_rst = 1'b0;
    repeat (1100) @(negedge i_clock);
  endtask : do_reset

  task automatic reg_acc(input logic wr, input logic [3:0] a, input logic [7:0] d,
                         output logic [7:0] q);
    logic [15:0] rx;
    spi.select(1'b1);
    spi.word({1'b1, wr, 2'h0, a, d}, rx);
    spi.select(1'b0);
    q = rx[7:0];
  endtask : reg_acc

  task automatic wait_ready(input int lim);
    n = 0;
    while (ready !== 1'b1 && n < lim) begin
      @(negedge i_clock);
      n++;
    end
  endtask : wait_ready

  function automatic logic [15:0] model_result(input int ch, input logic off_en);
    int v;
    v = modulator_bitstream[ch] ? 32'hFFFF : 0;
    if (off_en) v = v - offs[ch] + 32'h8000;
    if (v < 0) v = 0;
    if (v > 32'hFFFF) v = 32'hFFFF;
    return v[15:0];
  endfunction : model_result

  task automatic convert(input logic [2:0] mode, input logic [1:0] sel, input logic [7:0] cfg);
    int dec;
    int ord;
    int nch;
    int t;
    logic [15:0] rx;
    dec = (mode < 4) ? (128 << mode) : (64 << (mode - 4));
    ord = (mode < 4) ? 2 : 3;
    nch = (sel == 2'h0) ? 1 : (sel == 2'h1) ? 2 : 3;
    // Slowest selected channel sets the pace
    t = dec * ord * ((nch == 3) ? 106 : 100) / 10;
    modulator_bitstream = 3'($urandom);
    reg_acc(1'b1, 4'h1, {6'h0, sel}, rd);
    reg_acc(1'b1, 4'h0, cfg | {5'h0, mode}, rd);
    spi.select(1'b1);
    check("ready after start", 16'h0, {15'h0, ready});
    wait_ready(t + 500);
    check("conversion time", 16'h1, 16'(n > t - 60 && n < t + 80));
    spi.word(16'h8200, rx);
    check("ready bit in frame", 16'h1, rx);
    for (int c = 0; c < 4; c++) begin
      spi.word(16'h0000, rx);
      check("result word", (c < nch) ? model_result(c, cfg[5]) : 16'h0, rx);
    end
    spi.select(1'b0);
  endtask : convert

  // ****************************************
  // Sequence
  // ****************************************
  initial begin
    i_clock = 1'b0;
    i_sys_rst = 1'b1;
    mclk = 3'h0;
    modulator_bitstream = 3'h0;
    void'($urandom(67784));
    do_reset();
    check("int with no clock", 16'h0, {15'h0, int_n});
    spi.select(1'b1);
    check("output while faulted", 16'h0, {15'h0, miso_oe});
    spi.select(1'b0);
    mclk_run = 1'b1;
    do_reset();
    check("int with clock", 16'h1, {15'h0, int_n});
    for (int a = 0; a < 10; a++) begin
      reg_acc(1'b0, 4'(a), 8'h00, rd);
      check("reset value", (a >= 4 && a % 2 == 0) ? 16'h80 : 16'h0, {8'h0, rd});
    end
    reg_acc(1'b1, 4'h4, 8'h12, rd);
    reg_acc(1'b0, 4'h4, 8'h00, rd);
    check("read-only offset", 16'h80, {8'h0, rd});
    reg_acc(1'b1, 4'h0, 8'h25, rd);
    reg_acc(1'b0, 4'h0, 8'h00, rd);
    check("config readback", 16'h25, {8'h0, rd});
    modulator_bitstream = 3'h7;
    reg_acc(1'b1, 4'h1, 8'h02, rd);
    reg_acc(1'b1, 4'h0, 8'h46, rd);  // Cal on, correction off, third order x256
    spi.select(1'b1);
    wait_ready(9000);
    check("calibration done", 16'h1, {15'h0, ready});
    spi.select(1'b0);
    reg_acc(1'b1, 4'h0, 8'h06, rd);
    for (int a = 4; a < 10; a++) begin
      reg_acc(1'b0, 4'(a), 8'h00, rd);
      check("captured offset", 16'hFF, {8'h0, rd});
    end
    offs = '{32'hFFFF, 32'hFFFF, 32'hFFFF};
    for (int m = 0; m < 7; m++) begin
      convert(3'(m), 2'(m % 3), m[0] ? 8'h20 : 8'h00);
    end
    convert(3'h4, 2'h2, 8'h20);
    finish_test();
  end

  // Whole sequence needs roughly 90,000 cycles; stay under 98,000
  initial begin
    #980us;
    errors++;
    finish_test();
  end
endmodule : sinc_decimation_spi_readout_tb
